// file: status_indicator_control.sv
/*
 * Status indicator control: AHB-Lite register slave, status input
 * synchronisers, function decode, colour mixing and pin drivers.
 * Assumes status inputs arrive asynchronously and softReset is synchronous.
 */
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "status_indicator_defs.svh"
// What this block does
// RULE1: indicator 2 code 0010: on full duplex, blink collision, off half duplex.
// RULE2: indicator 2 codes 0110 on 10/1000 link, 0111 on 10 link.
// RULE3: codes 1000 off, 1001 on, 1010 high-z, 1011 blink; 11xx reserved.
// RULE4: 0001 link with activity blink, 0011 on activity, 0100 blink activity.
// RULE5: indicators 2 and 0 code 0101 on while transmitting.
// RULE6: indicator 1 select in bits 7:4; code 0000 on while receiving.
// RULE7: indicator 1: 0010 link/receive blink, 0101/0110/0111 speed or fiber.
// RULE8: indicator 0 select bits 3:2 both set overrides indicator 1 select.
// RULE9: indicator 0 code 0010 blinks 3/2/1/0 times by speed.
// RULE10: indicator 0 code 0110 on copper link, 0111 on 1000 link.
// RULE11: indicator 0 codes 1100/1110/1111 are dual modes 1/2/4; 1101 undefined.
// RULE12: 4-bit mix fields at 15:12 and 11:8, 12.5% steps, 1000 full.
// RULE13: software keeps mix at or below 50% for two-terminal diodes.
// RULE14: polarity 00 on low off high; 01 on high off low.
// RULE15: polarity 10 on low off high-z; 11 on high off high-z.
// RULE16: blink period selectable 42 to 670 ms, codes 000 to 100.
// RULE17: speed pulse on and off periods selectable 84 to 670 ms.
// RULE18: function, polarity and mix fields keep values over software reset.
// RULE19: in dual modes the mix sets each output's active fraction.
module status_indicator_control #(
	parameter int TICK_CYCLES = `MS_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic softReset,
	input wire logic linkUp,
	input wire logic [1:0] speed,
	input wire logic fullDuplex,
	input wire logic transmitting,
	input wire logic receiving,
	input wire logic collision,
	input wire logic fiberLink,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [2:0] indicatorOut,
	output logic [2:0] indicatorOeB
);
	logic [1:0] rstSync_q;
	logic rstN;
	logic [`ST_W-1:0] stRaw;
	logic [`ST_W-1:0] st_q;
	logic [15:0] func_q;
	logic [15:0] pol_q;
	logic [15:0] timer_q;
	logic dValid_q;
	logic dWrite_q;
	logic [7:0] dIdx_q;
	logic accept;
	logic [7:0] aIdx;
	logic aHit;
	logic [15:0] rdVal;
	logic [2:0] mixPhase_q;
	logic mixOn0;
	logic mixOn1;
	logic link;
	logic dualSel;
	logic dualOn;
	logic [1:0] dualAct;
	status_indicator_pkg::drive_t drv [3];
	timing_if tif ();

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstN = rstSync_q[1];

	assign stRaw = {fiberLink, collision, receiving, transmitting,
		fullDuplex, speed, linkUp};

	// three-stage synchronisers, update when stages two and three agree
	for (genvar b = 0; b < `ST_W; b++) begin : gSync
		logic [2:0] sh_q;
		always_ff @(posedge clk or negedge rstN) begin
			if (!rstN) begin
				sh_q <= 3'h0;
				st_q[b] <= 1'b0;
			end else begin
				sh_q <= {sh_q[1:0], stRaw[b]};
				if (sh_q[1] == sh_q[2]) begin
					st_q[b] <= sh_q[2];
				end
			end
		end
	end

	assign link = st_q[`ST_LINK];

	// AHB-Lite slave, zero wait states
	assign accept = hsel && hready && htrans[1];
	assign aIdx = haddr[`IDX_MSB:`ADDR_LSB];
	assign aHit = (haddr[31:`IDX_MSB+1] == 22'h000000);

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			dValid_q <= 1'b0;
			dWrite_q <= 1'b0;
			dIdx_q <= 8'h00;
		end else begin
			dValid_q <= accept && aHit;
			dWrite_q <= hwrite;
			dIdx_q <= aIdx;
		end
	end

	// register fields only take defaults at hardware reset
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			func_q <= `FUNC_RST; // RULE18
			pol_q <= `POL_RST; // RULE18
			timer_q <= `TIMER_RST;
		end else if (dValid_q && dWrite_q) begin
			case (dIdx_q)
				`IDX_FUNC: func_q <= hwdata[15:0];
				`IDX_POL: pol_q <= hwdata[15:0]; // RULE12
				`IDX_TIMER: timer_q <= hwdata[15:0] & `TIMER_MASK;
				default: ;
			endcase
		end
	end

	// read value, with forwarding of a write still in its data phase
	always_comb begin
		case (aIdx)
			`IDX_FUNC: rdVal = func_q;
			`IDX_POL: rdVal = pol_q;
			`IDX_TIMER: rdVal = timer_q;
			`IDX_STATUS: rdVal = {8'h00, st_q};
			default: rdVal = 16'h0000;
		endcase
		if (dValid_q && dWrite_q && dIdx_q == aIdx) begin
			case (aIdx)
				`IDX_FUNC: rdVal = hwdata[15:0];
				`IDX_POL: rdVal = hwdata[15:0];
				`IDX_TIMER: rdVal = hwdata[15:0] & `TIMER_MASK;
				default: ;
			endcase
		end
		if (!aHit) begin
			rdVal = 16'h0000;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (accept && !hwrite) begin
				hrdata <= {16'h0000, rdVal};
			end
		end
	end

	// timebase hookup
	assign tif.softReset = softReset;
	assign tif.blinkRate = timer_q[`RATE_HI:`RATE_LO]; // RULE16
	assign tif.onSel = timer_q[`ONP_HI:`ONP_LO]; // RULE17
	assign tif.offSel = timer_q[`OFFP_HI:`OFFP_LO]; // RULE17
	always_comb begin
		tif.speedCount = 2'h0;
		if (link) begin // RULE9
			case (st_q[`ST_SPD_HI:`ST_SPD_LO])
				`SPD_1000: tif.speedCount = 2'h3;
				`SPD_100: tif.speedCount = 2'h2;
				`SPD_10: tif.speedCount = 2'h1;
				default: tif.speedCount = 2'h0;
			endcase
		end
	end

	indicator_timebase #(.TICK_CYCLES(TICK_CYCLES)) uTimebase (
		.clk(clk),
		.rstN(rstN),
		.tb(tif.gen)
	);

	// colour mix: eight-phase duty cycle
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			mixPhase_q <= 3'h0;
		end else begin
			mixPhase_q <= mixPhase_q + 3'h1;
		end
	end
	assign mixOn0 = ({1'b0, mixPhase_q} < pol_q[`MIX0_HI:`MIX0_LO]); // RULE12
	assign mixOn1 = ({1'b0, mixPhase_q} < pol_q[`MIX1_HI:`MIX1_LO]); // RULE12

	function automatic status_indicator_pkg::drive_t fnDrive(
		input logic [1:0] ch, input logic [3:0] fn, input logic [7:0] st,
		input logic blink, input logic spdOn);
		logic lk;
		logic act;
		logic [1:0] sp;
		logic on;
		logic hiz;
		lk = st[`ST_LINK];
		act = st[`ST_TX] || st[`ST_RX];
		sp = st[`ST_SPD_HI:`ST_SPD_LO];
		on = 1'b0;
		hiz = 1'b0;
		case (fn)
			`FC_LINK: on = (ch == 2'd1) ? st[`ST_RX] : lk; // RULE6
			`FC_LINK_ACT: on = lk && !(act && blink); // RULE4
			`FC_MIXED2: begin
				if (ch == 2'd2) begin
					on = st[`ST_FDX] || (st[`ST_COL] && blink); // RULE1
				end else if (ch == 2'd1) begin
					on = lk && !(st[`ST_RX] && blink); // RULE7
				end else begin
					on = spdOn; // RULE9
				end
			end
			`FC_ACT_ON: on = act; // RULE4
			`FC_ACT_BLINK: on = act && blink; // RULE4
			`FC_TX: begin
				if (ch == 2'd1) begin
					on = lk && (sp == `SPD_100 || st[`ST_FIB]); // RULE7
				end else begin
					on = st[`ST_TX]; // RULE5
				end
			end
			`FC_SPD_A: begin
				if (ch == 2'd2) begin
					on = lk && (sp == `SPD_10 || sp == `SPD_1000); // RULE2
				end else if (ch == 2'd1) begin
					on = lk && (sp == `SPD_100 || sp == `SPD_1000); // RULE7
				end else begin
					on = lk && !st[`ST_FIB]; // RULE10
				end
			end
			`FC_SPD_B: begin
				if (ch == 2'd2) begin
					on = lk && sp == `SPD_10; // RULE2
				end else if (ch == 2'd1) begin
					on = lk && sp == `SPD_100; // RULE7
				end else begin
					on = lk && sp == `SPD_1000; // RULE10
				end
			end
			`FC_OFF: on = 1'b0; // RULE3
			`FC_ON: on = 1'b1; // RULE3
			`FC_HIZ: hiz = 1'b1; // RULE3
			`FC_BLINK: on = blink; // RULE3
			default: on = 1'b0;
		endcase
		if (hiz) begin
			fnDrive = status_indicator_pkg::DRV_HIZ;
		end else if (on) begin
			fnDrive = status_indicator_pkg::DRV_ON;
		end else begin
			fnDrive = status_indicator_pkg::DRV_OFF;
		end
	endfunction : fnDrive

	// dual-indicator modes on outputs 0 and 1
	assign dualSel = (func_q[`DUAL_HI:`DUAL_LO] == 2'b11); // RULE8
	always_comb begin
		dualOn = 1'b0;
		dualAct = 2'b00;
		case (func_q[`FN0_HI:`FN0_LO]) // RULE11
			`FC_DUAL1: begin
				dualOn = link && !((st_q[`ST_TX] || st_q[`ST_RX]) && tif.blink);
				dualAct = {mixOn1, mixOn0}; // RULE19
			end
			`FC_DUAL2: begin
				dualOn = link;
				if (st_q[`ST_SPD_HI:`ST_SPD_LO] == `SPD_1000) begin
					dualAct = {1'b0, mixOn0}; // RULE19
				end else begin
					dualAct = {mixOn1, 1'b0}; // RULE19
				end
			end
			`FC_DUAL4: begin
				dualOn = link;
				dualAct = tif.blink ? {1'b0, mixOn0} : {mixOn1, 1'b0}; // RULE19
			end
			default: dualOn = 1'b0;
		endcase
	end

	always_comb begin
		drv[2] = fnDrive(2'd2, func_q[`FN2_HI:`FN2_LO], st_q, tif.blink,
			tif.speedOn);
		drv[1] = fnDrive(2'd1, func_q[`FN1_HI:`FN1_LO], st_q, tif.blink,
			tif.speedOn);
		drv[0] = fnDrive(2'd0, func_q[`FN0_HI:`FN0_LO], st_q, tif.blink,
			tif.speedOn);
		if (dualSel) begin // RULE8
			drv[1] = (dualOn && dualAct[1]) ? status_indicator_pkg::DRV_ON :
				status_indicator_pkg::DRV_OFF;
			drv[0] = (dualOn && dualAct[0]) ? status_indicator_pkg::DRV_ON :
				status_indicator_pkg::DRV_OFF;
		end
	end

	// pin drivers with per-output polarity
	for (genvar i = 0; i < 3; i++) begin : gPin
		logic [1:0] pol;
		assign pol = pol_q[2*i+1:2*i];
		always_ff @(posedge clk or negedge rstN) begin
			if (!rstN) begin
				indicatorOut[i] <= 1'b1;
				indicatorOeB[i] <= 1'b1;
			end else begin
				case (drv[i])
					status_indicator_pkg::DRV_HIZ: begin
						indicatorOut[i] <= 1'b0;
						indicatorOeB[i] <= 1'b1;
					end
					status_indicator_pkg::DRV_ON: begin
						indicatorOut[i] <= pol[0]; // RULE14
						indicatorOeB[i] <= 1'b0;
					end
					default: begin
						indicatorOut[i] <= ~pol[0]; // RULE14
						indicatorOeB[i] <= pol[1]; // RULE15
					end
				endcase
			end
		end
	end
endmodule : status_indicator_control

// file: status_indicator_defs.svh
/*
 * Constants of the status indicator block: register indices, reset values,
 * field positions, function codes and blink timing.
 * Assumes inclusion by bare name before any use.
 */
`ifndef STATUS_INDICATOR_DEFS_SVH
`define STATUS_INDICATOR_DEFS_SVH

`define CLK_MHZ 250
`define MS_CYCLES (`CLK_MHZ * 1000)

`define ADDR_LSB 2
`define IDX_MSB 9
`define IDX_FUNC 8'h10
`define IDX_POL 8'h11
`define IDX_TIMER 8'h12
`define IDX_STATUS 8'h13

`define FUNC_RST 16'h101e
`define POL_RST 16'h4400
`define TIMER_RST 16'h0105
`define TIMER_MASK 16'h070f

`define FN2_HI 11
`define FN2_LO 8
`define FN1_HI 7
`define FN1_LO 4
`define FN0_HI 3
`define FN0_LO 0
`define DUAL_HI 3
`define DUAL_LO 2
`define MIX1_HI 15
`define MIX1_LO 12
`define MIX0_HI 11
`define MIX0_LO 8
`define RATE_HI 10
`define RATE_LO 8
`define OFFP_HI 3
`define OFFP_LO 2
`define ONP_HI 1
`define ONP_LO 0

`define FC_LINK 4'h0
`define FC_LINK_ACT 4'h1
`define FC_MIXED2 4'h2
`define FC_ACT_ON 4'h3
`define FC_ACT_BLINK 4'h4
`define FC_TX 4'h5
`define FC_SPD_A 4'h6
`define FC_SPD_B 4'h7
`define FC_OFF 4'h8
`define FC_ON 4'h9
`define FC_HIZ 4'ha
`define FC_BLINK 4'hb
`define FC_DUAL1 4'hc
`define FC_DUAL2 4'he
`define FC_DUAL4 4'hf

`define SPD_10 2'h0
`define SPD_100 2'h1
`define SPD_1000 2'h2

`define ST_W 8
`define ST_LINK 0
`define ST_SPD_LO 1
`define ST_SPD_HI 2
`define ST_FDX 3
`define ST_TX 4
`define ST_RX 5
`define ST_COL 6
`define ST_FIB 7

`define BLINK_MS_0 42
`define BLINK_MS_1 84
`define BLINK_MS_2 170
`define BLINK_MS_3 340
`define BLINK_MS_4 670
`define PULSE_MS_0 84
`define PULSE_MS_1 170
`define PULSE_MS_2 340
`define PULSE_MS_3 670
`define GAP_MULT 3

`endif

// file: status_indicator_pkg.sv
/*
 * Types shared by the status indicator modules.
 * Assumes nothing of its surroundings.
 */
package status_indicator_pkg;
	typedef enum logic [1:0] {DRV_OFF, DRV_ON, DRV_HIZ} drive_t;
	typedef enum logic [1:0] {SP_GAP, SP_ON, SP_OFF} speed_state_t;
endpackage : status_indicator_pkg

// file: timing_if.sv
/*
 * Carrier between the indicator control logic and its blink timebase.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface timing_if;
	logic softReset;
	logic [2:0] blinkRate;
	logic [1:0] onSel;
	logic [1:0] offSel;
	logic [1:0] speedCount;
	logic blink;
	logic speedOn;
	modport ctrl (output softReset, output blinkRate, output onSel,
		output offSel, output speedCount, input blink, input speedOn);
	modport gen (input softReset, input blinkRate, input onSel,
		input offSel, input speedCount, output blink, output speedOn);
endinterface : timing_if

// file: indicator_timebase.sv
/*
 * Blink and speed pulse timebase for the status indicators.
 * Assumes a synchronous active-low reset copy and a millisecond tick length.
 */
`timescale 1ns/1ps
`include "status_indicator_defs.svh"
module indicator_timebase #(
	parameter int TICK_CYCLES = `MS_CYCLES
) (
	input wire logic clk,
	input wire logic rstN,
	timing_if.gen tb
);
	logic [17:0] tickCnt_q;
	logic tick;
	logic [10:0] blinkCnt_q;
	logic [10:0] blinkHalf;
	logic blink_q;
	logic [10:0] msCnt_q;
	logic [1:0] pulses_q;
	logic [10:0] onMs;
	logic [10:0] offMs;
	status_indicator_pkg::speed_state_t spState_q;

	function automatic logic [10:0] pulseMs(input logic [1:0] sel);
		case (sel)
			2'h0: pulseMs = 11'(`PULSE_MS_0);
			2'h1: pulseMs = 11'(`PULSE_MS_1);
			2'h2: pulseMs = 11'(`PULSE_MS_2);
			default: pulseMs = 11'(`PULSE_MS_3);
		endcase
	endfunction : pulseMs

	assign tick = (tickCnt_q == 18'(TICK_CYCLES - 1));
	assign onMs = pulseMs(tb.onSel); // RULE17
	assign offMs = pulseMs(tb.offSel); // RULE17
	assign tb.blink = blink_q;
	assign tb.speedOn = (spState_q == status_indicator_pkg::SP_ON);

	always_comb begin
		case (tb.blinkRate) // RULE16
			3'h0: blinkHalf = 11'(`BLINK_MS_0 / 2);
			3'h1: blinkHalf = 11'(`BLINK_MS_1 / 2);
			3'h2: blinkHalf = 11'(`BLINK_MS_2 / 2);
			3'h3: blinkHalf = 11'(`BLINK_MS_3 / 2);
			3'h4: blinkHalf = 11'(`BLINK_MS_4 / 2);
			default: blinkHalf = 11'(`BLINK_MS_1 / 2);
		endcase
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			tickCnt_q <= 18'h00000;
		end else if (tick || tb.softReset) begin
			tickCnt_q <= 18'h00000;
		end else begin
			tickCnt_q <= tickCnt_q + 18'h00001;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			blinkCnt_q <= 11'h000;
			blink_q <= 1'b0;
		end else if (tb.softReset) begin
			blinkCnt_q <= 11'h000;
			blink_q <= 1'b0;
		end else if (tick) begin
			if (blinkCnt_q >= blinkHalf - 11'h001) begin // RULE16
				blinkCnt_q <= 11'h000;
				blink_q <= ~blink_q;
			end else begin
				blinkCnt_q <= blinkCnt_q + 11'h001;
			end
		end
	end

	// speed code: n pulses, then a long gap
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			spState_q <= status_indicator_pkg::SP_GAP;
			msCnt_q <= 11'h000;
			pulses_q <= 2'h0;
		end else if (tb.softReset) begin
			spState_q <= status_indicator_pkg::SP_GAP;
			msCnt_q <= 11'h000;
			pulses_q <= 2'h0;
		end else if (tick) begin
			msCnt_q <= msCnt_q + 11'h001;
			case (spState_q)
				status_indicator_pkg::SP_GAP: begin
					if (msCnt_q >= 11'(offMs * `GAP_MULT) - 11'h001) begin
						msCnt_q <= 11'h000;
						pulses_q <= 2'h0;
						if (tb.speedCount != 2'h0) begin // RULE9
							spState_q <= status_indicator_pkg::SP_ON;
						end
					end
				end
				status_indicator_pkg::SP_ON: begin
					if (msCnt_q >= onMs - 11'h001) begin // RULE17
						msCnt_q <= 11'h000;
						pulses_q <= pulses_q + 2'h1;
						spState_q <= status_indicator_pkg::SP_OFF;
					end
				end
				status_indicator_pkg::SP_OFF: begin
					if (msCnt_q >= offMs - 11'h001) begin // RULE17
						msCnt_q <= 11'h000;
						if (pulses_q >= tb.speedCount) begin // RULE9
							spState_q <= status_indicator_pkg::SP_GAP;
						end else begin
							spState_q <= status_indicator_pkg::SP_ON;
						end
					end
				end
				default: begin
					spState_q <= status_indicator_pkg::SP_GAP;
				end
			endcase
		end
	end
endmodule : indicator_timebase

// file: indicator_lamp_model.sv
/* Three discrete indicator lamps, each wired from a pin to ground.
   Assumes the pins are unpulled, so a released line shows the inverse of its last driven level. */
`timescale 1ns/1ps
module indicator_lamp_model (
	input wire logic [2:0] level,
	input wire logic [2:0] oeB,
	output logic [2:0] lit,
	output logic [2:0] lineLevel
);
	logic [2:0] lastQ;
	// remember the last driven level of each line
	always @* begin
		for (int i = 0; i < 3; i++) begin
			if (!oeB[i]) begin
				lastQ[i] = level[i];
			end
		end
	end
	// released line floats away from its last level
	assign lineLevel = (oeB & ~lastQ) | (~oeB & level);
	assign lit = ~oeB & level;
endmodule : indicator_lamp_model

// file: status_indicator_control_properties.sv
/* Assertions on indicator pins and register reads of the control block.
   Assumes hready is the block's own hreadyout. */
`timescale 1ns/1ps
`include "status_indicator_defs.svh"
module status_indicator_control_properties #(
	parameter int TICK_CYCLES = `MS_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic [2:0] indicatorOut,
	input wire logic [2:0] indicatorOeB
);
	logic apQ, wrQ, okQ, calm, wrData;
	logic [7:0] idxQ;
	logic [15:0] funcQ, polQ;
	logic [1:0] calmQ;
	localparam int HI_MAX = (`BLINK_MS_4 / 2 + 1) * TICK_CYCLES;
	logic [31:0] hiCnt_q;
	assign wrData = apQ && wrQ && okQ && hready;
	assign calm = calmQ == 2'h3;
	// address phase capture
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			apQ <= 1'b0;
			wrQ <= 1'b0;
			okQ <= 1'b0;
			idxQ <= 8'h0;
		end else if (hready) begin
			apQ <= hsel && htrans[1];
			wrQ <= hwrite;
			okQ <= haddr[31:10] == 22'h0;
			idxQ <= haddr[9:2];
		end
	end
	// shadow of the two configuration registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			funcQ <= `FUNC_RST;
			polQ <= `POL_RST;
		end else if (wrData && idxQ == `IDX_FUNC) begin
			funcQ <= hwdata[15:0];
		end else if (wrData && idxQ == `IDX_POL) begin
			polQ <= hwdata[15:0];
		end
	end
	// cycles since the last configuration change
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			calmQ <= 2'h0;
		end else if (wrData || !hreadyout) begin
			calmQ <= 2'h0;
		end else if (!calm) begin
			calmQ <= calmQ + 2'h1;
		end
	end
	// cycles indicator 2 has stayed high since the last configuration write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hiCnt_q <= 32'h0;
		end else if (!indicatorOut[2] || wrData) begin
			hiCnt_q <= 32'h0;
		end else if (hiCnt_q <= 32'(HI_MAX)) begin
			hiCnt_q <= hiCnt_q + 32'h1;
		end
	end
	function automatic logic isOff(logic [1:0] p, logic o, logic e);
		return p[1] ? e : (!e && o == !p[0]);
	endfunction : isOff
	function automatic logic isOn(logic [1:0] p, logic o, logic e);
		return !e && o == p[0];
	endfunction : isOn
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_force_off2;
		calm && funcQ[11:8] == `FC_OFF |->
			isOff(polQ[5:4], indicatorOut[2], indicatorOeB[2]);
	endproperty
	a_force_off2: assert property (p_force_off2)
		else $error("forced off level wrong");
	property p_force_on0;
		calm && funcQ[3:0] == `FC_ON |->
			isOn(polQ[1:0], indicatorOut[0], indicatorOeB[0]);
	endproperty
	a_force_on0: assert property (p_force_on0)
		else $error("forced on level wrong");
	property p_hiz1;
		calm && !wrData && funcQ[7:4] == `FC_HIZ && funcQ[3:2] != 2'h3 |->
			(indicatorOeB[1]) [*3];
	endproperty
	a_hiz1: assert property (p_hiz1)
		else $error("high impedance not held");
	property p_reserved2;
		calm && funcQ[11:10] == 2'h3 |->
			isOff(polQ[5:4], indicatorOut[2], indicatorOeB[2]);
	endproperty
	a_reserved2: assert property (p_reserved2)
		else $error("reserved code not off");
	property p_undef_dual;
		calm && funcQ[3:0] == 4'hd |->
			isOff(polQ[3:2], indicatorOut[1], indicatorOeB[1]) &&
			isOff(polQ[1:0], indicatorOut[0], indicatorOeB[0]);
	endproperty
	a_undef_dual: assert property (p_undef_dual)
		else $error("undefined dual code not off");
	property p_read_func;
		apQ && !wrQ && okQ && idxQ == `IDX_FUNC && hreadyout |->
			hrdata == {16'h0, funcQ};
	endproperty
	a_read_func: assert property (p_read_func)
		else $error("function select read wrong");
	property p_read_pol;
		apQ && !wrQ && okQ && idxQ == `IDX_POL && hreadyout |->
			hrdata == {16'h0, polQ};
	endproperty
	a_read_pol: assert property (p_read_pol)
		else $error("polarity read wrong");
	property p_blink2;
		calm && funcQ[11:8] == `FC_BLINK && polQ[5:4] == 2'h1 |->
			hiCnt_q <= 32'(HI_MAX);
	endproperty
	a_blink2: assert property (p_blink2)
		else $error("blink stuck on");
	cover property (calm && funcQ[3:0] == `FC_DUAL2);
	cover property (apQ && !wrQ && idxQ == `IDX_POL);
	cover property (calm && funcQ[3:0] == `FC_MIXED2 && $rose(indicatorOut[0]));
endmodule : status_indicator_control_properties

// file: status_indicator_control_tb.sv
/* Self-checking bench of the status indicator control block.
   Assumes a single slave whose hreadyout is the bus hready. */
`timescale 1ns/1ps
`include "status_indicator_defs.svh"
module status_indicator_control_tb;
	localparam int TK = 4;
	logic clk, rst_b, softReset, hsel, hwrite, hreadyout, hresp;
	logic [7:0] st;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, indicatorOut, indicatorOeB, lit;
	int err_total, checked, n, w, c, i;
	logic [2:0] acc;
	logic [15:0] fnT [19] = '{16'h0000, 16'h0000, 16'h0210, 16'h0210,
		16'h0637, 16'h0637, 16'h0765, 16'h0765, 16'h0576, 16'h0576,
		16'h0856, 16'h0920, 16'h089d, 16'h000e, 16'h000e, 16'h000c,
		16'h000f, 16'h0637, 16'h0444};
	logic [7:0] stT [19] = '{8'h01, 8'h21, 8'h09, 8'h01, 8'h15, 8'h03,
		8'h01, 8'h13, 8'h13, 8'h85, 8'h85, 8'h01, 8'h01, 8'h05, 8'h03,
		8'h01, 8'h00, 8'h04, 8'h01};
	logic [2:0] exT [19] = '{3'h5, 3'h7, 3'h7, 3'h3, 3'h7, 3'h0, 3'h4,
		3'h3, 3'h7, 3'h0, 3'h2, 3'h7, 3'h0, 3'h5, 3'h6, 3'h7, 3'h0, 3'h0,
		3'h0};
	logic [7:0] spT [4] = '{8'h05, 8'h03, 8'h01, 8'h00};
	int hfT [6] = '{21, 42, 85, 170, 335, 42};
	status_indicator_control #(.TICK_CYCLES(TK)) status_indicator_control_inst (
		.clk(clk), .rst_b(rst_b), .softReset(softReset),
		.linkUp(st[`ST_LINK]), .speed(st[`ST_SPD_HI:`ST_SPD_LO]),
		.fullDuplex(st[`ST_FDX]), .transmitting(st[`ST_TX]),
		.receiving(st[`ST_RX]), .collision(st[`ST_COL]),
		.fiberLink(st[`ST_FIB]), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .indicatorOut(indicatorOut),
		.indicatorOeB(indicatorOeB));
	indicator_lamp_model indicator_lamp_model_inst (.level(indicatorOut),
		.oeB(indicatorOeB), .lit(lit), .lineLevel());
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic print_verdict;
		if (err_total == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict
	task automatic hang;
		err_total++;
		$display("MISMATCH t=%0t timeout", $time);
		print_verdict();
	endtask : hang
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int k;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 99);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 99);
		q = hrdata;
		if (k >= 99) hang();
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, a, {16'h0, d}, q);
	endtask : wr
	task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, e);
	endtask : rdchk
	task automatic pins(input logic [2:0] eOut, input logic [2:0] eOe);
		repeat (6) @(posedge clk);
		check({29'h0, indicatorOut}, {29'h0, eOut});
		check({29'h0, indicatorOeB}, {29'h0, eOe});
	endtask : pins
	// one speed code train on indicator 0: pulse count and last on width
	task automatic blinks(output int cnt, output int wid);
		int low, hi, k;
		logic p;
		cnt = 0;
		wid = 0;
		low = 0;
		hi = 0;
		p = 1'b0;
		for (k = 0; k < 20000 && low < 800; k++) begin
			@(posedge clk);
			low = indicatorOut[0] ? 0 : low + 1;
		end
		if (low < 800) hang();
		low = 0;
		for (k = 0; k < 20000 && low < 800; k++) begin
			@(posedge clk);
			if (indicatorOut[0] && !p) cnt++;
			if (indicatorOut[0]) hi++;
			else if (p) wid = hi;
			if (!indicatorOut[0]) hi = 0;
			low = indicatorOut[0] ? 0 : low + 1;
			p = indicatorOut[0];
		end
		if (low < 800) hang();
	endtask : blinks
	task automatic rise(output int cyc);
		cyc = 0;
		while (indicatorOut[0] !== 1'b0 && cyc < 6000) begin
			@(posedge clk);
			cyc++;
		end
		while (indicatorOut[0] !== 1'b1 && cyc < 6000) begin
			@(posedge clk);
			cyc++;
		end
		if (cyc >= 6000) hang();
	endtask : rise
	initial begin
		rst_b = 1'b0;
		softReset = 1'b0;
		st = 8'h0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		err_total = 0;
		checked = 0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i < 20 && hreadyout !== 1'b1; i++) begin
			@(posedge clk);
		end
		rdchk(32'h40, 32'h101e);
		rdchk(32'h44, 32'h4400);
		wr(32'h80, 16'hffff);
		rdchk(32'h80, 32'h0);
		rdchk(32'h440, 32'h0);
		for (i = 0; i < 4; i++) begin
			wr(32'h44, 16'h4400 | 16'(i * 21));
			wr(32'h40, 16'h0989);
			pins({i[0], !i[0], i[0]}, {1'b0, i[1], 1'b0});
		end
		wr(32'h40, 16'h0aaa);
		pins(3'h0, 3'h7);
		// mix kept at 50% for bi-colour lamps
		wr(32'h44, 16'h4415);
		wr(32'h40, 16'h0c9d);
		pins(3'h0, 3'h0);
		for (i = 0; i < 19; i++) begin
			st <= stT[i];
			wr(32'h40, fnT[i]);
			repeat (5) @(posedge clk);
			acc = 3'h0;
			c = 0;
			// mixed outputs pulse: look across all eight mix phases
			for (w = 0; w < 8; w++) begin
				@(posedge clk);
				acc = acc | lit;
				c += lit[0];
			end
			check({29'h0, acc}, {29'h0, exT[i]});
			if (i == 13) check(32'(c), 32'h4);
		end
		softReset <= 1'b1;
		repeat (2) @(posedge clk);
		softReset <= 1'b0;
		rdchk(32'h40, 32'h0444);
		rdchk(32'h44, 32'h4415);
		wr(32'h48, 16'h0000);
		wr(32'h40, 16'h0002);
		for (i = 0; i < 4; i++) begin
			st <= spT[i];
			blinks(n, w);
			check(32'(n), 32'(3 - i));
			check(32'(w), (i < 3) ? 32'(84 * TK) : 32'h0);
		end
		st <= 8'h05;
		wr(32'h48, 16'h0001);
		blinks(n, w);
		check(32'(w), 32'(170 * TK));
		wr(32'h40, 16'h0b0b);
		for (i = 0; i < 6; i++) begin
			wr(32'h48, 16'(i << 8));
			rise(c);
			rise(c);
			rise(c);
			check(32'(c), 32'(2 * hfT[i] * TK));
		end
		print_verdict();
	end
endmodule : status_indicator_control_tb
bind status_indicator_control status_indicator_control_properties #(
	.TICK_CYCLES(TICK_CYCLES)
) status_indicator_control_properties_inst (.clk(clk), .rst_b(rst_b),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hrdata(hrdata), .indicatorOut(indicatorOut),
	.indicatorOeB(indicatorOeB));
